// ==== verilog/pru_update_sync.sv ====
// Register-update synchronization for one PWM generator
module pru_update_sync
   import pru_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control word write carrying both mode fields
   input wire logic ctl_wr,
   input wire logic [15:0] ctl_data,
   // Register writes from software
   input wire pru_write_t dbctl_wr,
   input wire pru_write_t genb_wr,
   // Events from the counter and the master control
   input wire pru_event_t evt,
   // Mode fields read back
   output logic [1:0] deadband_ctrl_update_mode,
   output logic [1:0] gen_b_action_update_mode,
   // Values in force at the generator
   output logic [DATA_W-1:0] deadband_control_reg,
   output logic [DATA_W-1:0] gen_b_action_reg,
   // Pending flags for software visibility
   output logic dbctl_pending,
   output logic genb_pending
);

   logic [1:0] dbmode_q;
   logic [1:0] gbmode_q;
   logic [DATA_W-1:0] db_shadow_q;
   logic [DATA_W-1:0] gb_shadow_q;
   logic db_pend_q;
   logic gb_pend_q;
   logic db_greq_q;
   logic gb_greq_q;
   logic db_xfer;
   logic gb_xfer;

   // Decide whether the pending shadow moves this cycle
   function automatic logic pru_xfer(input logic [1:0] mode, input logic pend,
                                     input logic armed, input pru_event_t e);
      logic ok;
      ok = 1'b0;
      if (pend && e.cnt_zero) begin
         if (mode == PRU_MODE_LOCAL) begin
            ok = 1'b1;
         end else if (mode == PRU_MODE_GLOBAL) begin
            ok = armed;
         end
      end
      return ok;
   endfunction

   assign db_xfer = pru_xfer(dbmode_q, db_pend_q, db_greq_q, evt);
   assign gb_xfer = pru_xfer(gbmode_q, gb_pend_q, gb_greq_q, evt);

   // Mode fields; reserved code 1 is stored as written, software must avoid it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dbmode_q <= PRU_MODE_RESET;
         gbmode_q <= PRU_MODE_RESET;
      end else if (ctl_wr) begin
         dbmode_q <= ctl_data[PRU_DBCTL_MODE_LSB +: PRU_MODE_W];
         gbmode_q <= ctl_data[PRU_GENB_MODE_LSB +: PRU_MODE_W];
      end
   end

   // Global request latch; a request in the same cycle as a transfer re-arms
   always_ff @(posedge clk) begin
      if (!resetn) begin
         db_greq_q <= 1'b0;
         gb_greq_q <= 1'b0;
      end else begin
         if (evt.global_req) begin
            db_greq_q <= 1'b1;
         end else if (db_xfer || !db_pend_q) begin
            db_greq_q <= 1'b0;
         end
         if (evt.global_req) begin
            gb_greq_q <= 1'b1;
         end else if (gb_xfer || !gb_pend_q) begin
            gb_greq_q <= 1'b0;
         end
      end
   end

   // Dead-band control: shadow and value in force
   always_ff @(posedge clk) begin
      if (!resetn) begin
         db_shadow_q <= '0;
         db_pend_q <= 1'b0;
         deadband_control_reg <= '0;
      end else begin
         if (db_xfer) begin
            deadband_control_reg <= db_shadow_q;
            db_pend_q <= 1'b0;
         end
         // A new write wins over a transfer in the same cycle
         if (dbctl_wr.wr) begin
            if (dbmode_q == PRU_MODE_IMMED) begin
               deadband_control_reg <= dbctl_wr.data[DATA_W-1:0];
               db_pend_q <= 1'b0;
            end else begin
               db_shadow_q <= dbctl_wr.data[DATA_W-1:0];
               db_pend_q <= 1'b1;
            end
         end
      end
   end

   // Generator B action: shadow and value in force
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gb_shadow_q <= '0;
         gb_pend_q <= 1'b0;
         gen_b_action_reg <= '0;
      end else begin
         if (gb_xfer) begin
            gen_b_action_reg <= gb_shadow_q;
            gb_pend_q <= 1'b0;
         end
         if (genb_wr.wr) begin
            if (gbmode_q == PRU_MODE_IMMED) begin
               gen_b_action_reg <= genb_wr.data[DATA_W-1:0];
               gb_pend_q <= 1'b0;
            end else begin
               gb_shadow_q <= genb_wr.data[DATA_W-1:0];
               gb_pend_q <= 1'b1;
            end
         end
      end
   end

   // Registered read-back outputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         deadband_ctrl_update_mode <= PRU_MODE_RESET;
         gen_b_action_update_mode <= PRU_MODE_RESET;
         dbctl_pending <= 1'b0;
         genb_pending <= 1'b0;
      end else begin
         deadband_ctrl_update_mode <= dbmode_q;
         gen_b_action_update_mode <= gbmode_q;
         dbctl_pending <= db_pend_q;
         genb_pending <= gb_pend_q;
      end
   end

   // Checks beside the logic
   a_immed_write: assert property (@(posedge clk) disable iff (!resetn)
      dbctl_wr.wr && dbmode_q == PRU_MODE_IMMED
      |=> deadband_control_reg == $past(dbctl_wr.data))
      else $error("immediate dead-band write not applied");
   a_genb_immed: assert property (@(posedge clk) disable iff (!resetn)
      genb_wr.wr && gbmode_q == PRU_MODE_IMMED
      |=> gen_b_action_reg == $past(genb_wr.data))
      else $error("immediate action write not applied");
   a_local_hold: assert property (@(posedge clk) disable iff (!resetn)
      db_pend_q && !evt.cnt_zero && !dbctl_wr.wr
      |=> $stable(deadband_control_reg))
      else $error("dead-band value changed without counter zero");
   a_gb_local_hold: assert property (@(posedge clk) disable iff (!resetn)
      gb_pend_q && !evt.cnt_zero && !genb_wr.wr
      |=> $stable(gen_b_action_reg))
      else $error("action value changed without counter zero");
   a_local_xfer: assert property (@(posedge clk) disable iff (!resetn)
      gb_pend_q && gbmode_q == PRU_MODE_LOCAL && evt.cnt_zero && !genb_wr.wr
      |=> gen_b_action_reg == $past(gb_shadow_q) && !gb_pend_q)
      else $error("local transfer of action value missed");
   a_db_local_xfer: assert property (@(posedge clk) disable iff (!resetn)
      db_pend_q && dbmode_q == PRU_MODE_LOCAL && evt.cnt_zero && !dbctl_wr.wr
      |=> deadband_control_reg == $past(db_shadow_q) && !db_pend_q)
      else $error("local transfer of dead-band value missed");
   a_global_wait: assert property (@(posedge clk) disable iff (!resetn)
      gb_pend_q && gbmode_q == PRU_MODE_GLOBAL && !gb_greq_q && !genb_wr.wr
      |=> $stable(gen_b_action_reg))
      else $error("global mode transferred without request");
   a_global_xfer: assert property (@(posedge clk) disable iff (!resetn)
      db_pend_q && dbmode_q == PRU_MODE_GLOBAL && db_greq_q && evt.cnt_zero
      && !dbctl_wr.wr |=> deadband_control_reg == $past(db_shadow_q))
      else $error("global transfer of dead-band value missed");
   a_greq_arm: assert property (@(posedge clk) disable iff (!resetn)
      evt.global_req |=> db_greq_q && gb_greq_q)
      else $error("global request not latched");
   // A write that meets a transfer must not be lost: it becomes the new pending value
   a_write_wins: assert property (@(posedge clk) disable iff (!resetn)
      db_xfer && dbctl_wr.wr
      |=> db_pend_q && db_shadow_q == $past(dbctl_wr.data)
      && deadband_control_reg == $past(db_shadow_q))
      else $error("write lost against same-cycle transfer");
   a_mode_store: assert property (@(posedge clk) disable iff (!resetn)
      ctl_wr |=> dbmode_q == $past(ctl_data[11:10])
      && gbmode_q == $past(ctl_data[9:8]))
      else $error("mode fields not stored");
   a_pend_set: assert property (@(posedge clk) disable iff (!resetn)
      genb_wr.wr && gbmode_q != PRU_MODE_IMMED |=> gb_pend_q ##1 genb_pending)
      else $error("pending not raised");
   a_reset_mode: assert property (@(posedge clk)
      !resetn |=> dbmode_q == 2'h0 && gbmode_q == 2'h0)
      else $error("modes not cleared by reset");
   a_reset_readback: assert property (@(posedge clk)
      !resetn |=> deadband_ctrl_update_mode == 2'h0 && gen_b_action_update_mode == 2'h0)
      else $error("mode read-back not cleared by reset");

   // Main scenarios the bench is expected to reach
   c_local: cover property (@(posedge clk) disable iff (!resetn) db_xfer
      && dbmode_q == PRU_MODE_LOCAL);
   c_global: cover property (@(posedge clk) disable iff (!resetn) gb_xfer
      && gbmode_q == PRU_MODE_GLOBAL);
   c_immed: cover property (@(posedge clk) disable iff (!resetn) genb_wr.wr
      && gbmode_q == PRU_MODE_IMMED);
   c_write_wins: cover property (@(posedge clk) disable iff (!resetn) db_xfer
      && dbctl_wr.wr);
   c_global_wait: cover property (@(posedge clk) disable iff (!resetn) gb_pend_q
      && gbmode_q == PRU_MODE_GLOBAL && evt.cnt_zero && !gb_greq_q);
endmodule

// ==== verilog/pru_pkg.sv ====
// Package for the PWM generator register-update synchronization block
package pru_pkg;
   // Update-mode field encodings
   typedef enum logic [1:0] {
      PRU_MODE_IMMED = 2'h0,
      PRU_MODE_RSVD = 2'h1,
      PRU_MODE_LOCAL = 2'h2,
      PRU_MODE_GLOBAL = 2'h3
   } pru_mode_t;

   // Field positions inside the generator control word
   localparam int PRU_DBCTL_MODE_LSB = 10;
   localparam int PRU_GENB_MODE_LSB = 8;
   localparam int PRU_MODE_W = 2;

   // Values after reset
   localparam pru_mode_t PRU_MODE_RESET = PRU_MODE_IMMED;

   // Write strobe with its data for one generator register
   typedef struct packed {
      logic wr;
      logic [31:0] data;
   } pru_write_t;

   // Counter events from the generator and the master control
   typedef struct packed {
      logic cnt_zero;
      logic global_req;
   } pru_event_t;
endpackage

// ==== dv/tb_top.sv ====
// Self-checking bench for the PWM generator register-update synchronization block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pru_pkg::*;

   // Stimulus and observed signals
   logic clk, resetn, ctl_wr, dbp, gbp;
   logic [15:0] ctl_data;
   pru_write_t dbw, gbw;
   pru_event_t ev;
   logic [1:0] dbm, gbm;
   logic [31:0] dbv, gbv;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;

   pru_update_sync pru_update_sync_inst (.clk(clk), .resetn(resetn), .ctl_wr(ctl_wr),
      .ctl_data(ctl_data), .dbctl_wr(dbw), .genb_wr(gbw), .evt(ev),
      .deadband_ctrl_update_mode(dbm), .gen_b_action_update_mode(gbm),
      .deadband_control_reg(dbv), .gen_b_action_reg(gbv),
      .dbctl_pending(dbp), .genb_pending(gbp));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard; the whole sequence needs well under a hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Both fields go in one control write; mode 1 is never used here
   task automatic set_mode(input pru_mode_t db, input pru_mode_t gb);
      ctl_wr = 1'b1;
      ctl_data = {4'h0, db, gb, 8'h00};
      tick(1);
      ctl_wr = 1'b0;
      tick(3);
      check({30'h0, dbm}, {30'h0, db});
      check({30'h0, gbm}, {30'h0, gb});
   endtask

   task automatic wr_both(input logic [31:0] a, input logic [31:0] b);
      dbw = '{1'b1, a};
      gbw = '{1'b1, b};
      tick(1);
      dbw.wr = 1'b0;
      gbw.wr = 1'b0;
   endtask

   task automatic pulse_zero();
      ev.cnt_zero = 1'b1;
      tick(1);
      ev.cnt_zero = 1'b0;
      tick(2);
   endtask

   task automatic expect_out(input logic [31:0] a, input logic [31:0] b, input logic p);
      check(dbv, a);
      check(gbv, b);
      check({31'h0, dbp}, {31'h0, p});
      check({31'h0, gbp}, {31'h0, p});
   endtask

   // Reset values, then immediate writes
   task automatic t_immediate();
      check({28'h0, dbm, gbm}, 32'h0000_0000);
      expect_out(32'h0000_0000, 32'h0000_0000, 1'b0);
      wr_both(32'hA5A5_0001, 32'h5A5A_0002);
      tick(1);
      check(dbv, 32'hA5A5_0001);
      check(gbv, 32'h5A5A_0002);
   endtask

   // Locally synchronized: held until the next counter zero, rewrite overwrites shadow
   task automatic t_local();
      set_mode(PRU_MODE_LOCAL, PRU_MODE_LOCAL);
      wr_both(32'h1111_1111, 32'h2222_2222);
      tick(1); // Strobe stays low for one edge between the two writes
      wr_both(32'h3333_3333, 32'h4444_4444);
      tick(4);
      expect_out(32'hA5A5_0001, 32'h5A5A_0002, 1'b1);
      pulse_zero();
      expect_out(32'h3333_3333, 32'h4444_4444, 1'b0);
   endtask

   // Globally synchronized: a bare counter zero does not move the shadow
   task automatic t_global();
      set_mode(PRU_MODE_GLOBAL, PRU_MODE_GLOBAL);
      wr_both(32'hDEAD_0003, 32'hBEEF_0004);
      pulse_zero();
      expect_out(32'h3333_3333, 32'h4444_4444, 1'b1);
      ev.global_req = 1'b1;
      tick(1);
      ev.global_req = 1'b0;
      tick(3);
      expect_out(32'h3333_3333, 32'h4444_4444, 1'b1);
      pulse_zero();
      expect_out(32'hDEAD_0003, 32'hBEEF_0004, 1'b0);
      set_mode(PRU_MODE_IMMED, PRU_MODE_IMMED);
   endtask

   // A write landing with counter zero: old shadow moves out, new one waits
   task automatic t_write_wins();
      set_mode(PRU_MODE_LOCAL, PRU_MODE_LOCAL);
      wr_both(32'h0000_00A1, 32'h0000_00B1);
      tick(1);
      ev.cnt_zero = 1'b1;
      wr_both(32'h0000_00A2, 32'h0000_00B2);
      ev.cnt_zero = 1'b0;
      tick(2);
      expect_out(32'h0000_00A1, 32'h0000_00B1, 1'b1);
      pulse_zero();
      expect_out(32'h0000_00A2, 32'h0000_00B2, 1'b0);
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      ctl_wr = 1'b0;
      ctl_data = 16'h0000;
      dbw = '0;
      gbw = '0;
      ev = '0;
      tick(3);
      resetn = 1'b1;
      tick(1);
      t_immediate();
      t_local();
      t_global();
      t_write_wins();
      results();
   end
endmodule
